// file: rtl/gate_scan_shift_register.sv
// gate_scan_shift_register: 200-stage bidirectional row-scan shifter
// assumes scan pins are asynchronous to clk_in and far slower (<=100 kHz)
// Contract
// - 200 stages, each drives one gate
// - capture input port bit on scan rise
// - every rise shifts chain one stage
// - far end bit out on scan fall
// - select high: a in, b out, upward
// - select low: b in, a out, downward
// - count select picks 200 or 192
// - 192 mode holds gates 97-104 low
// - 192 mode links stage 96 to 105
// - clear high forces all gates low
`timescale 1ns/1ps
`default_nettype none
module gate_scan_shift_register
(
  // clock and reset
  input  wire logic                                  clk_in,
  input  wire logic                                  rst_in,
  // scan clock and static selects
  input  wire logic                                  scan_clock_in,
  input  wire logic                                  scan_direction_select_in,
  input  wire logic                                  count_select_in,
  input  wire logic                                  output_clear_in,
  // data port a, three-signal two-way pin
  input  wire logic                                  data_port_a_in,
  output logic                                       data_port_a_out,
  output logic                                       data_port_a_oe_n_out,
  // data port b, three-signal two-way pin
  input  wire logic                                  data_port_b_in,
  output logic                                       data_port_b_out,
  output logic                                       data_port_b_oe_n_out,
  // gate outputs, bit 0 is gate 1
  output logic [gate_scan_pkg::STAGE_COUNT-1:0]      gate_outputs_out
);
  localparam int unsigned N = gate_scan_pkg::STAGE_COUNT;

  ////////////////////////////////////////////////////////////////////////
  // synchronised inputs
  logic                       scan_rise;   // scan clock rising pulse
  logic                       scan_fall;   // scan clock falling pulse
  logic                       dir_lvl;     // filtered direction select
  logic                       cnt_lvl;     // filtered count select
  logic                       clr_lvl;     // filtered output clear
  logic                       a_lvl;       // filtered port a
  logic                       b_lvl;       // filtered port b
  gate_scan_pkg::scan_ctrl_s  ctrl;        // grouped strap levels

  // scan clock edges
  pin_sync u_sync_clk (.clk_in(clk_in), .rst_in(rst_in), .pin_in(scan_clock_in),
                       .level_out(), .rise_out(scan_rise), .fall_out(scan_fall));
  // direction select
  pin_sync u_sync_dir (.clk_in(clk_in), .rst_in(rst_in), .pin_in(scan_direction_select_in),
                       .level_out(dir_lvl), .rise_out(), .fall_out());
  // count select
  // count select strap
  pin_sync u_sync_cnt (.clk_in(clk_in), .rst_in(rst_in), .pin_in(count_select_in),
                       .level_out(cnt_lvl), .rise_out(), .fall_out());
  // output clear
  pin_sync u_sync_clr (.clk_in(clk_in), .rst_in(rst_in), .pin_in(output_clear_in),
                       .level_out(clr_lvl), .rise_out(), .fall_out());
  // port a data
  pin_sync u_sync_a   (.clk_in(clk_in), .rst_in(rst_in), .pin_in(data_port_a_in),
                       .level_out(a_lvl), .rise_out(), .fall_out());
  // port b data
  pin_sync u_sync_b   (.clk_in(clk_in), .rst_in(rst_in), .pin_in(data_port_b_in),
                       .level_out(b_lvl), .rise_out(), .fall_out());

  // pack straps
  always_comb
  begin
    ctrl.dir_fwd   = dir_lvl;
    ctrl.count_192 = cnt_lvl;
    ctrl.clear     = clr_lvl;
  end

  // middle-range test, used by output masking only
  function automatic logic is_mid(input int unsigned idx);
    is_mid = (idx >= gate_scan_pkg::MID_FIRST) && (idx <= gate_scan_pkg::MID_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // shift chain
  logic [N-1:0] chain;        // stage bits, bit 0 is gate 1
  logic [N-1:0] next_chain;
  logic [N-1:0] up_src;       // source of each stage when shifting upward
  logic [N-1:0] dn_src;       // source of each stage when shifting downward

  // per-stage sources in both directions
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_src
      if (g == 0)
      begin : g_lo
        assign up_src[g] = a_lvl;
      end
      else if (g == gate_scan_pkg::MID_LAST + 1)
      begin : g_hi_gap
        assign up_src[g] = ctrl.count_192 ? chain[gate_scan_pkg::MID_FIRST-1] : chain[g-1];
      end
      else
      begin : g_up
        assign up_src[g] = chain[g-1];
      end
      if (g == N - 1)
      begin : g_top
        assign dn_src[g] = b_lvl;
      end
      else if (g == gate_scan_pkg::MID_FIRST - 1)
      begin : g_lo_gap
        assign dn_src[g] = ctrl.count_192 ? chain[gate_scan_pkg::MID_LAST+1] : chain[g+1];
      end
      else
      begin : g_dn
        assign dn_src[g] = chain[g+1];
      end
    end
  endgenerate

  // next chain: shift on every scan rise, clear never touches it
  always_comb
  begin
    next_chain = chain;
    if (scan_rise)
    begin
      if (ctrl.dir_fwd)
        next_chain = up_src;
      else
        next_chain = dn_src;
    end
  end

  // register chain
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      chain <= '0;
    else
      chain <= next_chain;
  end

  ////////////////////////////////////////////////////////////////////////
  // gate outputs
  logic [N-1:0] next_gates;

  // mask: middle eight in 192 mode, then clear
  always_comb
  begin
    for (int unsigned i = 0; i < N; i++)
    begin
      next_gates[i] = chain[i];
      if (ctrl.count_192 && is_mid(i))
        next_gates[i] = 1'b0;
      if (ctrl.clear)
        next_gates[i] = 1'b0;
    end
  end

  // register gates
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      gate_outputs_out <= '0;
    else
      gate_outputs_out <= next_gates;
  end

  ////////////////////////////////////////////////////////////////////////
  // cascade port drive
  logic next_a_out;
  logic next_b_out;
  logic next_a_oe_n;
  logic next_b_oe_n;

  // far-end bit leaves on scan fall, enables follow direction
  always_comb
  begin
    next_a_out  = data_port_a_out;
    next_b_out  = data_port_b_out;
    next_a_oe_n = ctrl.dir_fwd;
    next_b_oe_n = ~ctrl.dir_fwd;
    if (scan_fall)
    begin
      if (ctrl.dir_fwd)
        next_b_out = chain[N-1];
      else
        next_a_out = chain[0];
    end
  end

  // register port drive; both ports released during reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      data_port_a_out      <= gate_scan_pkg::PORT_RESET;
      data_port_b_out      <= gate_scan_pkg::PORT_RESET;
      data_port_a_oe_n_out <= 1'b1;
      data_port_b_oe_n_out <= 1'b1;
    end
    else
    begin
      data_port_a_out      <= next_a_out;
      data_port_b_out      <= next_b_out;
      data_port_a_oe_n_out <= next_a_oe_n;
      data_port_b_oe_n_out <= next_b_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  // every attempt is off while reset is high
  sequence s_rise_up;
    scan_rise && ctrl.dir_fwd;
  endsequence

  sequence s_rise_dn;
    scan_rise && !ctrl.dir_fwd;
  endsequence

  sequence s_fall_up;
    scan_fall && ctrl.dir_fwd;
  endsequence

  sequence s_fall_dn;
    scan_fall && !ctrl.dir_fwd;
  endsequence

  a_capture_port_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rise_up |=> chain[0] == $past(a_lvl)) else $error("port a not captured");

  a_capture_port_b: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rise_dn |=> chain[N-1] == $past(b_lvl)) else $error("port b not captured");

  a_shift_up_step: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rise_up |=> chain[10] == $past(chain[9])) else $error("upward shift wrong");

  a_shift_dn_step: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rise_dn |=> chain[9] == $past(chain[10])) else $error("downward shift wrong");

  a_hold_no_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    !scan_rise |=> $stable(chain)) else $error("chain moved without scan edge");

  a_bypass_up: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_rise_up and ctrl.count_192) |=> chain[104] == $past(chain[95])) else $error("bypass up wrong");

  a_bypass_dn: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_rise_dn and ctrl.count_192) |=> chain[95] == $past(chain[104])) else $error("bypass down wrong");

  a_mid_gates_low: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl.count_192 |=> gate_outputs_out[103:96] == 8'h00) else $error("middle gates not low");

  a_clear_gates: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl.clear |=> gate_outputs_out == '0) else $error("clear did not force low");

  a_gate_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl.clear |=> gate_outputs_out[0] == $past(chain[0])) else $error("gate 1 not following");

  a_clear_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
    (ctrl.clear and s_rise_up) |=> chain[1] == $past(chain[0])) else $error("clear stopped shift");

  a_cascade_out: assert property (@(posedge clk_in) disable iff (rst_in)
    s_fall_up |=> data_port_b_out == $past(chain[N-1]) && !data_port_b_oe_n_out)
    else $error("cascade out wrong");

  a_cascade_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !scan_fall |=> $stable(data_port_b_out) && $stable(data_port_a_out)) else $error("port out moved off fall");

  a_cascade_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_fall_dn |=> data_port_a_out == $past(chain[0]) && !data_port_a_oe_n_out)
    else $error("cascade out on port a wrong");

  a_port_enables: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> data_port_a_oe_n_out == $past(ctrl.dir_fwd) && data_port_b_oe_n_out == !$past(ctrl.dir_fwd))
    else $error("port enables do not follow direction");

  a_full_mid_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl.count_192 && !ctrl.clear |=> gate_outputs_out[103:96] == $past(chain[103:96]))
    else $error("middle gates not shown in full mode");

  a_no_bypass_up: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_rise_up and !ctrl.count_192) |=> chain[104] == $past(chain[103])) else $error("full chain skipped up");

  a_no_bypass_dn: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_rise_dn and !ctrl.count_192) |=> chain[95] == $past(chain[96])) else $error("full chain skipped down");
endmodule
`default_nettype wire

// file: rtl/gate_scan_pkg.sv
// gate_scan_pkg: shared constants and carriers for the gate row-scan shifter
// assumes a single 20 MHz system clock domain
package gate_scan_pkg;
  // chain geometry
  localparam int unsigned STAGE_COUNT   = 200;
  localparam int unsigned MID_FIRST     = 96;   // zero-based index of gate 97
  localparam int unsigned MID_LAST      = 103;  // zero-based index of gate 104
  // system clock
  localparam int unsigned CLK_PERIOD_NS = 50;
  // least clear pulse, in microseconds and in cycles (rounded up)
  localparam int unsigned CLEAR_MIN_US  = 1;
  localparam int unsigned CLEAR_MIN_CYC = (CLEAR_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_DEPTH    = 3;
  // reset values
  localparam logic        PORT_RESET    = 1'b0;
  // static strap pins gathered together
  typedef struct packed {
    logic dir_fwd;   // high: a to b, gate 1 toward 200
    logic count_192; // high: middle eight stages bypassed
    logic clear;     // high: all gate outputs low
  } scan_ctrl_s;
endpackage

// file: rtl/pin_sync.sv
// pin_sync: three-flop synchroniser with second/third agreement filter
// assumes the input comes from outside the clk_in domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // pin side
  input  wire logic pin_in,
  // filtered level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic [2:0] stage;        // synchroniser flops
  logic [2:0] next_stage;
  logic       next_level;   // filtered level
  logic       next_rise;
  logic       next_fall;

  // shift chain and filter: level changes once stages 1 and 2 agree
  always_comb
  begin
    next_stage = {stage[1:0], pin_in};
    next_level = level_out;
    next_rise  = 1'b0;
    next_fall  = 1'b0;
    if (stage[1] == stage[2] && stage[2] != level_out)
    begin
      next_level = stage[2];
      next_rise  = stage[2];
      next_fall  = ~stage[2];
    end
  end

  // register state
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stage     <= 3'h0;
      level_out <= 1'b0;
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end
    else
    begin
      stage     <= next_stage;
      level_out <= next_level;
      rise_out  <= next_rise;
      fall_out  <= next_fall;
    end
  end
endmodule
`default_nettype wire

// file: tb/scan_host_model.sv
// scan_host_model: timing controller that drives the scan clock and one serial bit
// assumes clk_in is the 20 MHz bench clock and the scan clock idles low
`timescale 1ns/1ps
`default_nettype none
module scan_host_model
(
  // bench clock
  input  wire logic clk_in,
  // scan link
  output logic      scan_clock_out,
  output logic      data_out
);
  // idle levels
  initial
  begin
    scan_clock_out = 1'b0;
    data_out       = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one scan pulse, entered just after a rising clock edge
  task automatic pulse(input logic bit_val);
    data_out = bit_val;
    repeat (5) @(posedge clk_in);
    #1 scan_clock_out = 1'b1;
    // bit held through the whole high phase
    repeat (10) @(posedge clk_in);
    #1 scan_clock_out = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// file: tb/test_gate_scan_shift_register.sv
// test_gate_scan_shift_register: self-checking bench for the row-scan shifter
// assumes the host model on the input port and direction and count selects held static between resets
`timescale 1ns/1ps
`default_nettype none
module test_gate_scan_shift_register;
  // clock, reset and static selects
  logic                                   clk_in;
  logic                                   rst_in;
  logic                                   dir;
  logic                                   cnt;
  logic                                   clr;
  // port pins and gates
  logic                                   a_out, a_oe_n, b_out, b_oe_n, scan, host_d;
  logic [gate_scan_pkg::STAGE_COUNT-1:0]  gates;
  int                                     mismatches = 0;
  int                                     cmp_count  = 0;
  // released line shows host data on the input side, else the inverse of its last value
  wire a_wire = !a_oe_n ? a_out : (dir ? host_d : ~a_out);
  wire b_wire = !b_oe_n ? b_out : (!dir ? host_d : ~b_out);

  gate_scan_shift_register gate_scan_shift_register_inst
  (
    .clk_in(clk_in), .rst_in(rst_in), .scan_clock_in(scan), .scan_direction_select_in(dir),
    .count_select_in(cnt), .output_clear_in(clr), .data_port_a_in(a_wire), .data_port_a_out(a_out),
    .data_port_a_oe_n_out(a_oe_n), .data_port_b_in(b_wire), .data_port_b_out(b_out),
    .data_port_b_oe_n_out(b_oe_n), .gate_outputs_out(gates)
  );
  scan_host_model scan_host_model_inst
  (
    .clk_in(clk_in), .scan_clock_out(scan), .data_out(host_d)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [199:0] got, input logic [199:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // reset with new static selects
  task automatic do_reset(input logic d, input logic c);
    @(posedge clk_in);
    #1 rst_in = 1'b1;
    dir = d;
    cnt = c;
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
  endtask
  task automatic shift_n(input logic v, input int n);
    repeat (n) scan_host_model_inst.pulse(v);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic run_forward;
    do_reset(1'b1, 1'b0);
    shift_n(1'b1, 2);
    shift_n(1'b0, 1);
    check(gates, 200'h6);
    check(b_oe_n, 1'b0);
    check(a_oe_n, 1'b1);
    shift_n(1'b0, 196);
    check(b_out, 1'b0);
    shift_n(1'b0, 1);
    check(gates, 200'h3 << 198);
    check(b_out, 1'b1);
  endtask
  task automatic run_reverse;
    do_reset(1'b0, 1'b0);
    shift_n(1'b1, 2);
    shift_n(1'b0, 1);
    check(gates, 200'h3 << 197);
    check({a_oe_n, b_oe_n}, 2'h1);
    shift_n(1'b0, 197);
    check(gates, 200'h3);
    check(a_out, 1'b1);
  endtask
  task automatic run_short;
    do_reset(1'b1, 1'b1);
    shift_n(1'b1, 1);
    shift_n(1'b0, 95);
    check(gates, 200'h1 << 95);
    shift_n(1'b0, 1);
    check(gates, 200'h1 << 104);
    shift_n(1'b0, 95);
    check(gates, 200'h1 << 199);
    check(b_out, 1'b1);
  endtask
  task automatic run_clear;
    do_reset(1'b1, 1'b0);
    shift_n(1'b1, 2);
    clr = 1'b1;
    repeat (gate_scan_pkg::CLEAR_MIN_CYC) @(posedge clk_in);
    #1;
    check(gates, 200'h0);
    shift_n(1'b0, 1);
    check(gates, 200'h0);
    clr = 1'b0;
    repeat (8) @(posedge clk_in);
    #1;
    check(gates, 200'h6);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock, watchdog and main sequence
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (100000) @(posedge clk_in);
    mismatches++;
    finish_test();
  end
  initial
  begin
    rst_in = 1'b1;
    dir    = 1'b1;
    cnt    = 1'b0;
    clr    = 1'b0;
    run_forward();
    run_reverse();
    run_short();
    run_clear();
    finish_test();
  end
endmodule
`default_nettype wire
